// file: verilog/tdpwm_core.sv
`timescale 1ns/1ns
`default_nettype none
module tdpwm_core
  import tdpwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_wdata,
  input wire logic duty_we,
  input wire logic [7:0] duty_wdata,
  input wire logic period_we,
  input wire logic [7:0] period_wdata,
  input wire logic sub_clk_pin,
  output logic [7:0] timer_control_reg,
  output logic [7:0] duty_compare_reg,
  output logic [7:0] period_compare_reg,
  output logic [7:0] count,
  output logic timer_irq,
  output logic pulse_width_out_pin,
  output logic divider_out_pin
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] duty_hold;
    logic [7:0] duty_act;
    logic [7:0] period;
    logic [7:0] cnt;
    logic tff;
    logic irq;
    logic pwm_pin;
    logic pdo_pin;
    logic [2:0] sub_sync;
    logic sub_tick;
  } tdpwm_st_t;
  tdpwm_st_t st;
  tdpwm_st_t next_st;
  logic tick;
  logic run;
  logic pwm_mode;
  logic div_mode;
  logic duty_hit;
  logic ovf_hit;
  logic per_hit;

  ////////////////////////////////////////////////////////////////
  // Source clock prescaler
  tdpwm_tick u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clk_sel(st.ctrl[CTRL_CLK_LSB +: 3]),
    .sub_tick(st.sub_tick),
    .tick(tick)
  );

  // Decoded control fields
  assign run = st.ctrl[CTRL_RUN_BIT];
  // Mode field decode, shared by both output modes
  function automatic logic mode_is(input logic [7:0] c, input logic [2:0] m);
    mode_is = (c[CTRL_MODE_LSB +: 3] == m);
  endfunction : mode_is
  assign pwm_mode = mode_is(st.ctrl, MODE_PWM);
  assign div_mode = mode_is(st.ctrl, MODE_DIVIDER);
  assign duty_hit = run && tick && pwm_mode && (st.cnt == st.duty_act);
  assign ovf_hit = run && tick && pwm_mode && (st.cnt == CNT_MAX);
  assign per_hit = run && tick && div_mode && (st.cnt == st.period);

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_st = st;
    next_st.irq = 1'b0;
    // Sub clock pin: two flops, then edge detect on later stages
    next_st.sub_sync = {st.sub_sync[1:0], sub_clk_pin};
    next_st.sub_tick = st.sub_sync[1] & ~st.sub_sync[2];
    if (ctrl_we)
    begin
      next_st.ctrl = ctrl_wdata;
      // Preset only applies while stopped, so a stopping write keeps the level
      if (!ctrl_wdata[CTRL_RUN_BIT] && !run)
        next_st.tff = ctrl_wdata[CTRL_TFF_BIT];
      else if (ctrl_wdata[CTRL_RUN_BIT] && !run)
        next_st.tff = ctrl_wdata[CTRL_TFF_BIT];
    end
    if (period_we)
      next_st.period = period_wdata;
    // Duty holding stage; running pulse-width mode writes wait for the overflow transfer
    if (duty_we)
    begin
      next_st.duty_hold = duty_wdata;
      if (!run || !pwm_mode)
        next_st.duty_act = duty_wdata;
    end
    if (run && tick)
    begin
      if (pwm_mode)
      begin
        next_st.cnt = st.cnt + 8'h01;
        if (ovf_hit)
        begin
          // Same-cycle write transfers the new value directly
          next_st.cnt = 8'h00;
          next_st.irq = 1'b1;
          next_st.duty_act = duty_we ? duty_wdata : st.duty_hold;
        end
        if (duty_hit ^ ovf_hit)
          next_st.tff = ~st.tff;
      end
      else if (div_mode)
      begin
        next_st.cnt = st.cnt + 8'h01;
        if (per_hit)
        begin
          next_st.cnt = 8'h00;
          next_st.irq = 1'b1;
          next_st.tff = ~st.tff;
        end
      end
      else
        next_st.cnt = st.cnt + 8'h01;
    end
    // Pins follow the inverted flip-flop; stopped timer never toggles it
    next_st.pwm_pin = ~next_st.tff;
    next_st.pdo_pin = ~next_st.tff;
  end

  ////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.duty_hold <= DUTY_RESET;
      st.duty_act <= DUTY_RESET;
      st.period <= PERIOD_RESET;
      st.tff <= 1'b0;
      st.pwm_pin <= 1'b1;
      st.pdo_pin <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Outputs straight from flops
  assign timer_control_reg = st.ctrl;
  assign duty_compare_reg = st.duty_act;
  assign period_compare_reg = st.period;
  assign count = st.cnt;
  assign timer_irq = st.irq;
  assign pulse_width_out_pin = st.pwm_pin;
  assign divider_out_pin = st.pdo_pin;

  ////////////////////////////////////////////////////////////////
  // Checks
  chk_pin_inverse: assert property (@(posedge clk_sys) disable iff (!rstn)
    pulse_width_out_pin == ~st.tff)
    else $error("pwm pin not inverse of flip-flop");
  chk_ovf_irq: assert property (@(posedge clk_sys) disable iff (!rstn)
    ovf_hit |=> timer_irq && count == 8'h00)
    else $error("overflow did not clear and interrupt");
  chk_ovf_toggle: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ovf_hit && !duty_hit) |=> pulse_width_out_pin != $past(pulse_width_out_pin))
    else $error("overflow did not toggle pin");
  chk_duty_toggle: assert property (@(posedge clk_sys) disable iff (!rstn)
    (duty_hit && !ovf_hit) |=> pulse_width_out_pin != $past(pulse_width_out_pin) && count == $past(count) + 8'h01)
    else $error("duty match misbehaved");
  chk_count_up: assert property (@(posedge clk_sys) disable iff (!rstn)
    (run && tick && pwm_mode && count != 8'hff) |=> count == $past(count) + 8'h01)
    else $error("counter did not increment");
  chk_stop_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!run && !ctrl_we && !$past(ctrl_we)) |=> $stable(pulse_width_out_pin))
    else $error("stopped pin changed");
  chk_run_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    (run && pwm_mode && duty_we && !ovf_hit) |=> duty_compare_reg == $past(duty_compare_reg))
    else $error("running duty write took effect early");
  chk_stop_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!run && duty_we) |=> duty_compare_reg == $past(duty_wdata))
    else $error("stopped duty write not immediate");
  chk_per_match: assert property (@(posedge clk_sys) disable iff (!rstn)
    per_hit |=> timer_irq && count == 8'h00 && divider_out_pin != $past(divider_out_pin))
    else $error("period match misbehaved");
  chk_irq_src: assert property (@(posedge clk_sys) disable iff (!rstn)
    timer_irq |-> $past(ovf_hit || per_hit))
    else $error("spurious interrupt");

  ////////////////////////////////////////////////////////////////
  // Further checks on holding stage, presets and counting

  // Divider pin mirrors the inverted flip-flop
  chk_div_inverse: assert property (@(posedge clk_sys) disable iff (!rstn)
    divider_out_pin == ~st.tff)
    else $error("divider pin not inverse of flip-flop");

  // Coincident duty match and overflow cancel out
  chk_duty_cancel: assert property (@(posedge clk_sys) disable iff (!rstn)
    (duty_hit && ovf_hit) |=> pulse_width_out_pin == $past(pulse_width_out_pin))
    else $error("coincident match and overflow toggled pin");

  // Overflow shifts the holding stage into the active compare
  chk_ovf_shift: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ovf_hit && !duty_we) |=> duty_compare_reg == $past(st.duty_hold))
    else $error("overflow did not shift holding stage");

  // A write landing on overflow goes straight through
  chk_ovf_direct: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ovf_hit && duty_we) |=> duty_compare_reg == $past(duty_wdata))
    else $error("write at overflow not loaded");

  // Every duty write lands in the holding stage
  chk_hold_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    duty_we |=> st.duty_hold == $past(duty_wdata))
    else $error("holding stage not loaded");

  // Stopped counter never moves
  chk_stop_count: assert property (@(posedge clk_sys) disable iff (!rstn)
    !run |=> count == $past(count))
    else $error("stopped counter moved");

  // No tick, no count
  chk_idle_tick: assert property (@(posedge clk_sys) disable iff (!rstn)
    (run && !tick) |=> count == $past(count))
    else $error("counter moved without tick");

  // Preset while staying stopped drives the pin at once
  chk_preset_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_we && !run && !ctrl_wdata[CTRL_RUN_BIT]) |=> pulse_width_out_pin == !$past(ctrl_wdata[CTRL_TFF_BIT]))
    else $error("stopped preset not applied");

  // Starting write also loads the preset
  chk_preset_start: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_we && !run && ctrl_wdata[CTRL_RUN_BIT]) |=> divider_out_pin == !$past(ctrl_wdata[CTRL_TFF_BIT]))
    else $error("starting preset not applied");

  // Stopping write keeps the level, so the pin does not glitch
  chk_stopping_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_we && run && !ctrl_wdata[CTRL_RUN_BIT] && !duty_hit && !ovf_hit && !per_hit)
    |=> pulse_width_out_pin == $past(pulse_width_out_pin))
    else $error("stopping write changed pin");

  // Control write readable next cycle
  chk_ctrl_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctrl_we |=> timer_control_reg == $past(ctrl_wdata))
    else $error("control write lost");

  // Period register has no holding stage
  chk_period_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    period_we |=> period_compare_reg == $past(period_wdata))
    else $error("period write lost");

  // Divider counts up between matches
  chk_div_count: assert property (@(posedge clk_sys) disable iff (!rstn)
    (run && tick && div_mode && !per_hit) |=> count == $past(count) + 8'h01)
    else $error("divider counter did not increment");

  // Stopped divider holds its pin
  chk_div_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!run && !ctrl_we && !$past(ctrl_we)) |=> divider_out_pin == $past(divider_out_pin))
    else $error("stopped divider pin changed");

  // A stopped timer raises no interrupt
  chk_irq_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
    !run |=> !timer_irq)
    else $error("interrupt while stopped");

  // Reads show the active stage until the next overflow
  chk_read_stage: assert property (@(posedge clk_sys) disable iff (!rstn)
    (run && pwm_mode && !ovf_hit) |=> duty_compare_reg == $past(duty_compare_reg))
    else $error("active duty changed between overflows");

  // Interrupt always comes with a cleared counter
  chk_irq_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    timer_irq |-> count == 8'h00)
    else $error("interrupt without cleared counter");

  // Duty match never clears the counter
  chk_duty_noclr: assert property (@(posedge clk_sys) disable iff (!rstn)
    (duty_hit && !ovf_hit) |=> count != 8'h00)
    else $error("duty match cleared counter");

  // Period is the full 256 ticks: no interrupt short of the top
  chk_pwm_period: assert property (@(posedge clk_sys) disable iff (!rstn)
    (run && tick && pwm_mode && count != 8'hff) |=> !timer_irq)
    else $error("pwm interrupt before overflow");

  // Outside pulse-width mode duty writes are immediate
  chk_plain_duty: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!pwm_mode && duty_we) |=> duty_compare_reg == $past(duty_wdata))
    else $error("duty write outside pwm not immediate");
endmodule : tdpwm_core
`default_nettype wire

// file: verilog/tdpwm_pkg.sv
package tdpwm_pkg;
  // Control register field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_CLK_LSB = 4;
  localparam int CTRL_TFF_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // Mode field encodings
  localparam logic [2:0] MODE_DIVIDER = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  // Source clock select encodings (system clock division ratios, plus the sub clock pin)
  localparam logic [2:0] CLK_DIV2048 = 3'h0;
  localparam logic [2:0] CLK_DIV128 = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV8 = 3'h3;
  localparam logic [2:0] CLK_SUB = 3'h4;
  localparam logic [2:0] CLK_DIV2 = 3'h5;
  localparam logic [2:0] CLK_DIV1 = 3'h6;
  localparam int PRESC_W = 11;
endpackage : tdpwm_pkg

// file: verilog/tdpwm_tick.sv
`timescale 1ns/1ns
`default_nettype none
module tdpwm_tick
  import tdpwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [2:0] clk_sel,
  input wire logic sub_tick,
  output logic tick
);
  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic tick;
  } tdpwm_tick_st_t;
  tdpwm_tick_st_t st;
  tdpwm_tick_st_t next_st;

  ////////////////////////////////////////////////////////////////
  // Free running prescaler; one-cycle tick at the chosen tap
  always_comb
  begin
    next_st = st;
    next_st.presc = st.presc + 11'h001;
    unique case (clk_sel)
      CLK_DIV2048: next_st.tick = (st.presc == 11'h7ff);
      CLK_DIV128: next_st.tick = (st.presc[6:0] == 7'h7f);
      CLK_DIV32: next_st.tick = (st.presc[4:0] == 5'h1f);
      CLK_DIV8: next_st.tick = (st.presc[2:0] == 3'h7);
      CLK_SUB: next_st.tick = sub_tick;
      CLK_DIV2: next_st.tick = st.presc[0];
      default: next_st.tick = 1'b1; // Unused codes run at full rate
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;
endmodule : tdpwm_tick
`default_nettype wire

// file: test/tdpwm_load.sv
`timescale 1ns/1ns
`default_nettype none
module tdpwm_load
(
  input wire logic clk_sys,
  input wire logic pin,
  output int last_hi
);
  int run = 0;
  logic latch_one = 1'b1;
  logic seen;
  // Port latch held at one, else the timer never reaches the load
  assign seen = pin & latch_one;
  // Length of each high stretch, kept when the line falls
  always @(posedge clk_sys)
  begin
    if (seen === 1'b1)
      run <= run + 1;
    else
    begin
      if (run != 0)
        last_hi <= run;
      run <= 0;
    end
  end
endmodule : tdpwm_load
`default_nettype wire

// file: test/timer_divider_pwm_output_bench.sv
`timescale 1ns/1ns
`default_nettype none
module timer_divider_pwm_output_bench;
  import tdpwm_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ctrl_we = 1'b0;
  logic duty_we = 1'b0;
  logic period_we = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] ctrl_q, duty_q, period_q, cnt, c;
  logic irq, pwm_pin, div_pin, p;
  int err_total = 0;
  int n_checks = 0;
  int n, h1, h2, last_hi;
  // Stopped register writes: kind in the top bits, data below
  logic [9:0] rows [6] = '{10'h203, 10'h2ff, 10'h100, 10'h1ff, 10'h011, 10'h001};
  tdpwm_core tdpwm_core_inst (.clk_sys(clk_sys), .rstn(rstn), .ctrl_we(ctrl_we), .ctrl_wdata(wd),
    .duty_we(duty_we), .duty_wdata(wd), .period_we(period_we), .period_wdata(wd), .sub_clk_pin(1'b0),
    .timer_control_reg(ctrl_q), .duty_compare_reg(duty_q), .period_compare_reg(period_q), .count(cnt),
    .timer_irq(irq), .pulse_width_out_pin(pwm_pin), .divider_out_pin(div_pin));
  tdpwm_load tdpwm_load_inst (.clk_sys(clk_sys), .pin(pwm_pin), .last_hi(last_hi));
  // 100 ns system clock
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One write pulse, taken at the second edge; sampled at the falling edge
  task wr(input logic [1:0] k, input logic [7:0] d);
    @(posedge clk_sys);
    ctrl_we <= (k == 2'd0);
    duty_we <= (k == 2'd1);
    period_we <= (k == 2'd2);
    wd <= d;
    @(posedge clk_sys);
    ctrl_we <= 1'b0;
    duty_we <= 1'b0;
    period_we <= 1'b0;
    @(negedge clk_sys);
  endtask : wr
  // Bounded wait for the irq pulse, n is the cycles spent
  task wait_irq;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (irq !== 1'b1 && n < 3000);
    if (n >= 3000)
    begin
      err_total++;
      $display("[ERR] %0t no irq", $time);
      close_out();
    end
  endtask : wait_irq
  task rst_chk;
    chk(ctrl_q, 8'h00);
    chk(duty_q, 8'h00);
    chk(period_q, 8'h00);
    chk(cnt, 8'h00);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, pwm_pin}, 8'h01);
    chk({7'h00, div_pin}, 8'h01);
  endtask : rst_chk
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    rst_chk();
    // Table of stopped writes, each readable next cycle
    foreach (rows[i])
    begin
      wr(rows[i][9:8], rows[i][7:0]);
      chk(rows[i][9] ? period_q : (rows[i][8] ? duty_q : ctrl_q), rows[i][7:0]);
    end
    // Pulse width at full rate
    wr(2'd0, 8'h62);
    wr(2'd1, 8'h40);
    chk(duty_q, 8'h40);
    wr(2'd0, 8'h6a);
    wait_irq();
    c = cnt;
    @(posedge clk_sys);
    #1;
    chk(cnt, c + 8'h01);
    wait_irq();
    chk(8'(n + 1), 8'h00);
    wait_irq();
    h1 = last_hi;
    wr(2'd1, 8'h80);
    chk(duty_q, 8'h40);
    wait_irq();
    chk(duty_q, 8'h80);
    wait_irq();
    wait_irq();
    h2 = last_hi;
    chk(8'(h2 - h1), 8'h40);
    // Stop holds the pin, a later separate write presets it
    repeat (100) @(posedge clk_sys);
    wr(2'd0, 8'h62);
    p = pwm_pin;
    c = cnt;
    repeat (20) @(negedge clk_sys);
    chk({7'h00, pwm_pin}, {7'h00, p});
    chk(cnt, c);
    wr(2'd0, 8'he2);
    chk({7'h00, pwm_pin}, 8'h00);
    wr(2'd0, 8'h62);
    chk({7'h00, pwm_pin}, 8'h01);
    // Divider at full rate, period match every four ticks
    wr(2'd2, 8'h03);
    wr(2'd0, 8'h69);
    wait_irq();
    p = div_pin;
    wait_irq();
    chk(8'(n), 8'h04);
    chk({7'h00, div_pin}, {7'h00, ~p});
    // Divide by 128 setup, then start
    wr(2'd0, 8'h11);
    chk(ctrl_q, 8'h11);
    wr(2'd0, 8'h19);
    wait_irq();
    wait_irq();
    chk(8'(n >> 7), 8'h04);
    wr(2'd0, 8'h11);
    p = div_pin;
    repeat (600) @(negedge clk_sys);
    chk({7'h00, div_pin}, {7'h00, p});
    // Reset in mid-run
    wr(2'd0, 8'h19);
    repeat (300) @(posedge clk_sys);
    rstn <= 1'b0;
    @(negedge clk_sys);
    rst_chk();
    @(posedge clk_sys);
    rstn <= 1'b1;
    wr(2'd1, 8'h5a);
    chk(duty_q, 8'h5a);
    close_out();
  end
endmodule : timer_divider_pwm_output_bench
`default_nettype wire
